// ---- hw/responder_defs.svh ----
`ifndef RESPONDER_DEFS_SVH
`define RESPONDER_DEFS_SVH

// 4-bit reply codes
`define ACK_CODE        4'hA
`define NAK_ARG         4'h0
`define NAK_CRC         4'h1
`define NAK_AUTH        4'h4
`define NAK_NVM         4'h5

// activation replies
`define ATQA_LO         8'h44
`define ATQA_HI         8'h00
`define SAK_VAL         8'h00

// command codes
`define CMD_REQA        8'h26
`define CMD_WUPA        8'h52
`define CMD_SEL_CL2     8'h95
`define SEL_NVB         8'h70
`define CMD_VERSION     8'h60
`define CMD_READ        8'h30
`define CMD_AUTH        8'h1B

// memory variants
`define LAST_PAGE_S     8'h2C
`define LAST_PAGE_M     8'h86
`define LAST_PAGE_L     8'hE6
`define SIZE_S          8'h0F
`define SIZE_M          8'h11
`define SIZE_L          8'h13

// version bytes that carry no identity
`define VER_HDR         8'h00
`define VER_MINOR       8'h00
`define VER_PROTO       8'h03

// lengths and indexes
`define ATQA_LAST       3'h1
`define VER_LAST        3'h7
`define IDX_HDR         3'h0
`define IDX_VENDOR      3'h1
`define IDX_TYPE        3'h2
`define IDX_SUBTYPE     3'h3
`define IDX_MAJOR       3'h4
`define IDX_MINOR       3'h5
`define IDX_SIZE        3'h6
`define LAST_IN_GROUP   2'h3
`define FIFO_DEPTH      4

// frame delay n=9: (n*128+84) carrier periods at 13.56 MHz, clock 250 MHz
`define FDT_N           9
`define FDT_MUL         128
`define FDT_ADD         84
`define FC_KHZ          13560
`define CLK_KHZ         250000
`define REPLY_DELAY_CYC (((`FDT_N*`FDT_MUL+`FDT_ADD)*`CLK_KHZ+`FC_KHZ-1)/`FC_KHZ)
`define DELAY_W         16

`endif

// ---- hw/responder_pkg.sv ----
package responder_pkg;

  typedef enum logic [1:0] {VAR_144, VAR_504, VAR_888} variant_e;
  typedef enum logic [1:0] {RK_NIB, RK_ATQA, RK_SAK, RK_VER} reply_e;
  typedef enum logic [2:0] {ST_IDLE, ST_SEND, ST_RD_ADDR, ST_RD_WAIT, ST_RD_PUSH} state_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       short7;
    logic       err;
  } rx_byte_s;

  typedef struct packed {
    logic       nibble;
    logic       last;
    logic [7:0] data;
  } tx_item_s;

  typedef struct packed {
    state_e      st;
    reply_e      kind;
    logic [3:0]  code;
    logic [2:0]  idx;
    logic [7:0]  cmd;
    logic [7:0]  arg;
    logic [1:0]  nbytes;
    logic [7:0]  page;
    logic [1:0]  pcnt;
    logic [1:0]  bcnt;
    logic [31:0] word;
    logic [15:0] delay;
    tx_item_s    tx;
    logic        tx_valid;
    logic [7:0]  mem_page;
    logic        busy;
  } core_s;

endpackage

// ---- hw/reply_fifo.sv ----
`timescale 1ns/100ps
module reply_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } fifo_s;

  fifo_s s_q;
  fifo_s s_d;
  logic  push;
  logic  pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign in_ready  = (s_q.cnt != CW'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr          = bump(s_q.wr);
    end
    if (pop) begin
      s_d.rd = bump(s_q.rd);
    end
    if (push && !pop) begin
      s_d.cnt = CW'(s_q.cnt + 1'b1);
    end else if (pop && !push) begin
      s_d.cnt = CW'(s_q.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // reply_fifo

// ---- hw/tag_read_version_responder.sv ----
// Summary of operation
// - a positive acknowledge goes out as the 4-bit code Ah
// - an invalid argument such as a bad page is answered with nibble 0h
// - a parity or CRC error in the command is answered with nibble 1h
// - an overflowed failed-authentication counter is answered with nibble 4h
// - a failed non-volatile write is reported with nibble 5h
// - REQA or WUPA gets ATQA 00 44h, low byte 44h sent first
// - select at cascade level two gets SAK 00h
// - ATQA bits 7 and 8 code UID size, whatever the UID usage
// - version query is 60h plus CRC; reply is 8 bytes plus CRC
// - size byte: upper seven bits exponent n, LSB set if not exact power
// - size byte is 0Fh, 11h or 13h for 144, 504, 888 bytes
// - no reply before frame delay n=9; reader times out at 5 ms
// - read request is 30h, one start page byte, two CRC bytes
// - a valid read returns 16 bytes of four consecutive pages plus CRC
// - start page limit is 2Ch, 86h or E6h; above it a negative acknowledge
// - past the last page the read wraps to page 00h until four pages sent
// - locked and protected: start at or above protection start is refused
// - locked: lower start returns data, wrapping at the protection start page
// - once unlocked, reads behave as with no protection at all
// - password and password acknowledge pages always read as 00h
`timescale 1ns/100ps
`include "responder_defs.svh"
module tag_read_version_responder #(
  parameter int REPLY_DELAY_CYC = `REPLY_DELAY_CYC,
  parameter logic [7:0] VENDOR_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] PROD_TYPE = 8'h3C, // arbitrary value
  parameter logic [7:0] PROD_SUB  = 8'h7E, // arbitrary value
  parameter logic [7:0] PROD_MAJ  = 8'h09  // arbitrary value
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // received command bytes, crc already checked
  input  wire responder_pkg::rx_byte_s  rx,
  // events from the write and authentication engines
  input  wire logic                     write_ok,
  input  wire logic                     write_fail,
  input  wire logic                     auth_locked,
  // configuration
  input  wire responder_pkg::variant_e  variant,
  input  wire logic [7:0]               protection_start_page,
  input  wire logic                     unlocked_state,
  // page memory, asynchronous read
  output logic [7:0]                    mem_page,
  input  wire logic [31:0]              mem_rdata,
  // reply stream towards the frame encoder
  output responder_pkg::tx_item_s       tx,
  output logic                          tx_valid,
  input  wire logic                     tx_ready,
  // status
  output logic                          busy
);

  // ------------------------------------------------------------
  // state and fifo wiring
  // ------------------------------------------------------------
  responder_pkg::core_s    s_q;
  responder_pkg::core_s    s_d;
  responder_pkg::tx_item_s push_item;
  responder_pkg::tx_item_s fifo_out;
  logic                    push_valid;
  logic                    push_ready;
  logic                    fifo_valid;
  logic                    fifo_pop;
  logic [7:0]              last_page;
  logic [7:0]              wrap_page;
  logic                    prot_on;

  reply_fifo #(
    .WIDTH ($bits(responder_pkg::tx_item_s)),
    .DEPTH (`FIFO_DEPTH)
  ) u_reply_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (push_item),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign mem_page = s_q.mem_page;
  assign tx       = s_q.tx;
  assign tx_valid = s_q.tx_valid;
  assign busy     = s_q.busy;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // variant limit
  function automatic logic [7:0] limit_of(input responder_pkg::variant_e v);
    case (v)
      responder_pkg::VAR_144: limit_of = `LAST_PAGE_S;
      responder_pkg::VAR_504: limit_of = `LAST_PAGE_M;
      default:                limit_of = `LAST_PAGE_L;
    endcase
  endfunction

  function automatic logic [7:0] size_of(input responder_pkg::variant_e v);
    case (v)
      responder_pkg::VAR_144: size_of = `SIZE_S;
      responder_pkg::VAR_504: size_of = `SIZE_M;
      default:                size_of = `SIZE_L;
    endcase
  endfunction

  function automatic responder_pkg::tx_item_s nib(input logic [3:0] code);
    nib.nibble = 1'b1;
    nib.last   = 1'b1;
    nib.data   = {4'h0, code};
  endfunction

  function automatic responder_pkg::tx_item_s byte_item(input logic [7:0] d, input logic l);
    byte_item.nibble = 1'b0;
    byte_item.last   = l;
    byte_item.data   = d;
  endfunction

  function automatic logic [7:0] ver_byte(input logic [2:0] i, input responder_pkg::variant_e v);
    case (i)
      `IDX_HDR:     ver_byte = `VER_HDR;
      `IDX_VENDOR:  ver_byte = VENDOR_ID;
      `IDX_TYPE:    ver_byte = PROD_TYPE;
      `IDX_SUBTYPE: ver_byte = PROD_SUB;
      `IDX_MAJOR:   ver_byte = PROD_MAJ;
      `IDX_MINOR:   ver_byte = `VER_MINOR;
      `IDX_SIZE:    ver_byte = size_of(v);
      default:      ver_byte = `VER_PROTO;
    endcase
  endfunction

  // ------------------------------------------------------------
  // access window
  // ------------------------------------------------------------
  // the two top pages hold password and its acknowledge
  assign last_page = limit_of(variant);
  assign prot_on   = (protection_start_page <= last_page);

  always_comb begin
    if (prot_on && !unlocked_state && protection_start_page != 8'h00) begin
      wrap_page = 8'(protection_start_page - 8'h01);
    end else begin
      wrap_page = last_page;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] cmd_v;
    logic [7:0] arg_v;
    logic [1:0] cnt_v;
    logic [7:0] b;
    s_d        = s_q;
    push_valid = 1'b0;
    push_item  = '0;
    fifo_pop   = 1'b0;
    cmd_v      = (s_q.nbytes == 2'h0) ? rx.data : s_q.cmd;
    arg_v      = (s_q.nbytes == 2'h1) ? rx.data : s_q.arg;
    cnt_v      = (s_q.nbytes == 2'h3) ? s_q.nbytes : 2'(s_q.nbytes + 2'h1);
    b          = 8'h00;

    // output stage: the delay holds back the first byte of a reply
    if (s_q.tx_valid && tx_ready) begin
      s_d.tx_valid = 1'b0;
    end
    if (s_q.delay != '0) begin
      s_d.delay = 16'(s_q.delay - 16'h1);
    end
    if (!s_d.tx_valid && s_q.delay == '0 && fifo_valid) begin
      fifo_pop     = 1'b1;
      s_d.tx       = fifo_out;
      s_d.tx_valid = 1'b1;
    end

    case (s_q.st)
      responder_pkg::ST_IDLE: begin
        if (rx.valid) begin
          s_d.cmd    = cmd_v;
          s_d.arg    = arg_v;
          s_d.nbytes = cnt_v;
          s_d.idx    = '0;
          if (rx.last) begin
            s_d.nbytes = '0;
            s_d.delay  = 16'(REPLY_DELAY_CYC);
            if (rx.err) begin
              s_d.kind = responder_pkg::RK_NIB;
              s_d.code = `NAK_CRC;
              s_d.st   = responder_pkg::ST_SEND;
            end else if (rx.short7 && (cmd_v == `CMD_REQA || cmd_v == `CMD_WUPA)) begin
              s_d.kind = responder_pkg::RK_ATQA;
              s_d.st   = responder_pkg::ST_SEND;
            end else if (rx.short7) begin
              s_d.st = responder_pkg::ST_IDLE;
            end else if (cmd_v == `CMD_SEL_CL2 && arg_v == `SEL_NVB) begin
              s_d.kind = responder_pkg::RK_SAK;
              s_d.st   = responder_pkg::ST_SEND;
            end else if (cmd_v == `CMD_VERSION && cnt_v == 2'h1) begin
              s_d.kind = responder_pkg::RK_VER;
              s_d.st   = responder_pkg::ST_SEND;
            end else if (cmd_v == `CMD_READ && cnt_v == 2'h2) begin
              if (arg_v > last_page) begin
                s_d.kind = responder_pkg::RK_NIB;
                s_d.code = `NAK_ARG;
                s_d.st   = responder_pkg::ST_SEND;
              end else if (prot_on && !unlocked_state && arg_v >= protection_start_page) begin
                s_d.kind = responder_pkg::RK_NIB;
                s_d.code = `NAK_ARG;
                s_d.st   = responder_pkg::ST_SEND;
              end else begin
                s_d.page = arg_v;
                s_d.pcnt = '0;
                s_d.st   = responder_pkg::ST_RD_ADDR;
              end
            end else if (cmd_v == `CMD_AUTH && auth_locked) begin
              s_d.kind = responder_pkg::RK_NIB;
              s_d.code = `NAK_AUTH;
              s_d.st   = responder_pkg::ST_SEND;
            end
          end
        end else if (write_fail) begin
          s_d.kind = responder_pkg::RK_NIB;
          s_d.code = `NAK_NVM;
          s_d.st   = responder_pkg::ST_SEND;
        end else if (write_ok) begin
          s_d.kind = responder_pkg::RK_NIB;
          s_d.code = `ACK_CODE;
          s_d.st   = responder_pkg::ST_SEND;
        end
      end

      responder_pkg::ST_SEND: begin
        push_valid = 1'b1;
        case (s_q.kind)
          responder_pkg::RK_NIB: begin
            push_item = nib(s_q.code);
          end
          responder_pkg::RK_ATQA: begin
            b         = (s_q.idx == '0) ? `ATQA_LO : `ATQA_HI;
            push_item = byte_item(b, s_q.idx == `ATQA_LAST);
          end
          responder_pkg::RK_SAK: begin
            push_item = byte_item(`SAK_VAL, 1'b1);
          end
          default: begin
            push_item = byte_item(ver_byte(s_q.idx, variant), s_q.idx == `VER_LAST);
          end
        endcase
        if (push_ready) begin
          s_d.idx = 3'(s_q.idx + 3'h1);
          if (push_item.last) begin
            s_d.st = responder_pkg::ST_IDLE;
          end
        end
      end

      responder_pkg::ST_RD_ADDR: begin
        s_d.mem_page = s_q.page;
        s_d.st       = responder_pkg::ST_RD_WAIT;
      end

      responder_pkg::ST_RD_WAIT: begin
        if (s_q.mem_page >= 8'(last_page - 8'h01)) begin
          s_d.word = '0;
        end else begin
          s_d.word = mem_rdata;
        end
        s_d.bcnt = '0;
        s_d.st   = responder_pkg::ST_RD_PUSH;
      end

      responder_pkg::ST_RD_PUSH: begin
        push_valid = 1'b1;
        push_item  = byte_item(s_q.word[8*s_q.bcnt +: 8],
                               s_q.pcnt == `LAST_IN_GROUP && s_q.bcnt == `LAST_IN_GROUP);
        if (push_ready) begin
          s_d.bcnt = 2'(s_q.bcnt + 2'h1);
          if (s_q.bcnt == `LAST_IN_GROUP) begin
            s_d.pcnt = 2'(s_q.pcnt + 2'h1);
            s_d.page = (s_q.page >= wrap_page) ? 8'h00 : 8'(s_q.page + 8'h01);
            s_d.st   = (s_q.pcnt == `LAST_IN_GROUP) ? responder_pkg::ST_IDLE : responder_pkg::ST_RD_ADDR;
          end
        end
      end

      default: begin
        s_d.st = responder_pkg::ST_IDLE;
      end
    endcase

    s_d.busy = (s_d.st != responder_pkg::ST_IDLE);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // tag_read_version_responder

// ---- testbench/responder_monitor.sv ----
`timescale 1ns/100ps
module responder_monitor #(
  parameter int REPLY_DELAY_CYC = 8
) (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst_n,
  // command side
  input wire responder_pkg::rx_byte_s rx,
  input wire logic                    write_ok,
  input wire logic                    write_fail,
  input wire logic                    auth_locked,
  input wire responder_pkg::variant_e variant,
  input wire logic [7:0]              protection_start_page,
  input wire logic                    unlocked_state,
  // memory and reply side
  input wire logic [7:0]              mem_page,
  input wire logic [31:0]             mem_rdata,
  input wire responder_pkg::tx_item_s tx,
  input wire logic                    tx_valid,
  input wire logic                    tx_ready,
  input wire logic                    busy
);
  localparam int MAXW = REPLY_DELAY_CYC + 60;
  logic [7:0]  prev_q;
  logic [7:0]  last_pg;
  logic [15:0] since_q;
  logic        fin;
  assign fin = rx.valid && rx.last && !busy;
  always_comb begin
    case (variant)
      responder_pkg::VAR_504: last_pg = 8'h86;
      responder_pkg::VAR_888: last_pg = 8'hE6;
      default:                last_pg = 8'h2C;
    endcase
  end
  // saturates so write replies long after a frame never look early
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q  <= 8'h00;
      since_q <= 16'hFFFF;
    end else begin
      if (rx.valid && !busy) prev_q <= rx.data;
      if (fin) since_q <= 16'h0000;
      else if (since_q != 16'hFFFF) since_q <= since_q + 16'h0001;
    end
  end
  //--------------------------------------------------------------
  // properties
  //--------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_nib(logic [3:0] c);
    tx_valid && tx.nibble && tx.data[3:0] == c;
  endsequence
  sequence s_req;
    fin && rx.short7 && !rx.err && (rx.data == 8'h26 || rx.data == 8'h52);
  endsequence
  sequence s_lo;
    tx_valid && tx_ready && !tx.nibble && !tx.last && tx.data == 8'h44;
  endsequence
  sequence s_hi;
    tx_valid && !tx.nibble && tx.last && tx.data == 8'h00;
  endsequence
  AST_ACK_CODE: assert property (write_ok && !write_fail && !busy && !rx.valid && !tx_valid |-> ##[1:8] s_nib(4'hA))
    else $error("write ack code missing");
  AST_NVM_CODE: assert property (write_fail && !busy && !rx.valid && !tx_valid |-> ##[1:8] s_nib(4'h5))
    else $error("write failure code missing");
  AST_CRC_CODE: assert property (fin && rx.err |-> ##[1:MAXW] s_nib(4'h1))
    else $error("frame error code missing");
  AST_REPLY_GAP: assert property ($rose(tx_valid) |-> since_q >= REPLY_DELAY_CYC)
    else $error("reply sent too early");
  AST_ATQA_ORDER: assert property (s_req |-> ##[1:MAXW] s_lo ##[1:MAXW] s_hi)
    else $error("activation reply wrong");
  AST_SAK_ZERO: assert property (fin && !rx.err && rx.data == 8'h70 && prev_q == 8'h95 |-> ##[1:MAXW] s_hi)
    else $error("select reply wrong");
  AST_PAGE_LIMIT: assert property (fin && !rx.err && prev_q == 8'h30 && rx.data > last_pg |-> ##[1:MAXW] s_nib(4'h0))
    else $error("page beyond limit not refused");
  AST_LOCK_NAK: assert property (fin && !rx.err && prev_q == 8'h30 && protection_start_page <= last_pg &&
    !unlocked_state && rx.data >= protection_start_page |-> ##[1:MAXW] s_nib(4'h0))
    else $error("protected page not refused");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx))
    else $error("reply item changed while stalled");
endmodule // responder_monitor

// ---- testbench/reader_model.sv ----
`timescale 1ns/100ps
module reader_model (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // reply stream
  input  wire responder_pkg::tx_item_s tx,
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  // pacing: slow accepts every other cycle
  input  wire logic                    slow
);
  responder_pkg::tx_item_s got[$];
  logic                    ph;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph       <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) got.push_back(tx);
      ph       <= !ph;
      tx_ready <= !slow || ph;
    end
  end
endmodule // reader_model

// ---- testbench/test_tag_read_version_responder.sv ----
`timescale 1ns/100ps
module test_tag_read_version_responder;
  localparam int         DLY = 8;
  localparam int         GAP = 4;
  localparam int         LIMIT = 20000;
  localparam logic [7:0] VEN = 8'h6B; // arbitrary value
  localparam logic [7:0] TYP = 8'h2D; // arbitrary value
  localparam logic [7:0] SUB = 8'h71; // arbitrary value
  localparam logic [7:0] MAJ = 8'h05; // arbitrary value
  localparam logic [7:0] SZ [3] = '{8'h0F, 8'h11, 8'h13};
  localparam logic [7:0] LP [3] = '{8'h2C, 8'h86, 8'hE6};
  localparam int         MEM [3] = '{144, 504, 888};
  logic                    clk, rst_n, write_ok, write_fail, auth_locked, unlocked_state;
  logic                    tx_valid, tx_ready, busy, slow, tv_seen;
  logic [7:0]              prot, mem_page;
  logic [31:0]             mem_rdata;
  responder_pkg::rx_byte_s rx;
  responder_pkg::variant_e variant;
  responder_pkg::tx_item_s tx;
  int                      errors, compares, cyc, t0, tv_at;
  assign mem_rdata = {mem_page ^ 8'h03, mem_page ^ 8'h02, mem_page ^ 8'h01, mem_page};
  tag_read_version_responder #(
    .REPLY_DELAY_CYC(DLY), .VENDOR_ID(VEN), .PROD_TYPE(TYP), .PROD_SUB(SUB), .PROD_MAJ(MAJ)
  ) u_tag_read_version_responder (
    .clk(clk), .rst_n(rst_n), .rx(rx), .write_ok(write_ok), .write_fail(write_fail), .auth_locked(auth_locked),
    .variant(variant), .protection_start_page(prot), .unlocked_state(unlocked_state), .mem_page(mem_page),
    .mem_rdata(mem_rdata), .tx(tx), .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy)
  );
  reader_model u_reader_model (.clk(clk), .rst_n(rst_n), .tx(tx), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_valid && !tv_seen) begin
      tv_seen <= 1'b1;
      tv_at   <= cyc;
    end
    if (cyc == LIMIT) begin
      errors++;
      final_report();
    end
  end
  //--------------------------------------------------------------
  // shared tasks
  //--------------------------------------------------------------
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic send(input logic [7:0] b[], input logic s7, input logic er);
    logic lst;
    u_reader_model.got.delete();
    tv_seen = 1'b0;
    foreach (b[i]) begin
      lst = (i == b.size() - 1);
      rx = '{1'b1, b[i], lst, s7, er && lst};
      @(negedge clk);
    end
    t0 = cyc - 1;
    rx = '0;
  endtask
  task automatic reply(input logic [7:0] e[], input logic nib, input logic dl);
    int w;
    responder_pkg::tx_item_s g;
    w = 0;
    while ((u_reader_model.got.size() == 0 || !u_reader_model.got[$].last) && w < 400) begin
      @(negedge clk);
      w++;
    end
    if (dl) check({7'h00, (tv_at - t0 > DLY) && (tv_at - t0 <= DLY + 6)}, 8'h01);
    check(8'(u_reader_model.got.size()), 8'(e.size()));
    foreach (e[i]) begin
      g = u_reader_model.got[i];
      check(nib ? {4'h0, g.data[3:0]} : g.data, e[i]);
      check({7'h00, g.nibble}, {7'h00, nib});
    end
    while (busy === 1'b1 && w < 800) begin
      @(negedge clk);
      w++;
    end
    repeat (GAP) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] pg, input logic [7:0] wrap, input logic [7:0] lastpg, input logic ok);
    logic [7:0] e[];
    logic [7:0] p;
    send('{8'h30, pg}, 1'b0, 1'b0);
    if (!ok) begin
      reply('{8'h00}, 1'b1, 1'b1);
      return;
    end
    e = new[16];
    p = pg;
    for (int i = 0; i < 16; i++) begin
      e[i] = (p >= lastpg - 8'h01) ? 8'h00 : p ^ 8'(i % 4);
      if (i % 4 == 3) p = (p == wrap) ? 8'h00 : p + 8'h01;
    end
    reply(e, 1'b0, 1'b1);
  endtask
  task automatic wr(input logic ok, input logic fl, input logic [7:0] e);
    u_reader_model.got.delete();
    write_ok   = ok;
    write_fail = fl;
    @(negedge clk);
    write_ok   = 1'b0;
    write_fail = 1'b0;
    reply('{e}, 1'b1, 1'b0);
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  //--------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------
  task automatic t_activation();
    check({6'h00, tx_valid, busy}, 8'h00);
    check(mem_page, 8'h00);
    send('{8'h26}, 1'b1, 1'b0);
    reply('{8'h44, 8'h00}, 1'b0, 1'b1);
    check({6'h00, u_reader_model.got[0].data[7:6]}, 8'h01);
    send('{8'h52}, 1'b1, 1'b0);
    reply('{8'h44, 8'h00}, 1'b0, 1'b1);
    send('{8'h95, 8'h70}, 1'b0, 1'b0);
    reply('{8'h00}, 1'b0, 1'b1);
    $display("test activation done");
  endtask
  task automatic t_version();
    for (int v = 0; v < 3; v++) begin
      variant = responder_pkg::variant_e'(v);
      send('{8'h60}, 1'b0, 1'b0);
      reply('{8'h00, VEN, TYP, SUB, MAJ, 8'h00, SZ[v], 8'h03}, 1'b0, 1'b1);
      check({1'b0, u_reader_model.got[6].data[7:1]}, 8'($clog2(MEM[v]) - 1));
      check({7'h00, u_reader_model.got[6].data[0]}, 8'h01);
    end
    $display("test version done");
  endtask
  task automatic t_read();
    variant = responder_pkg::VAR_144;
    slow    = 1'b1;
    rd(8'h03, 8'h2C, 8'h2C, 1'b1);
    slow    = 1'b0;
    rd(8'h2A, 8'h2C, 8'h2C, 1'b1);
    for (int v = 0; v < 3; v++) begin
      variant = responder_pkg::variant_e'(v);
      rd(LP[v], LP[v], LP[v], 1'b1);
      rd(LP[v] + 8'h01, LP[v], LP[v], 1'b0);
    end
    $display("test read done");
  endtask
  task automatic t_protect();
    variant = responder_pkg::VAR_888;
    prot    = 8'h10;
    rd(8'h10, 8'hE6, 8'hE6, 1'b0);
    rd(8'h0E, 8'h0F, 8'hE6, 1'b1);
    unlocked_state = 1'b1;
    rd(8'h10, 8'hE6, 8'hE6, 1'b1);
    unlocked_state = 1'b0;
    prot    = 8'hFF;
    $display("test protect done");
  endtask
  task automatic t_codes();
    send('{8'h30, 8'h05}, 1'b0, 1'b1);
    reply('{8'h01}, 1'b1, 1'b1);
    auth_locked = 1'b1;
    send('{8'h1B, 8'h11, 8'h22, 8'h33, 8'h44}, 1'b0, 1'b0);
    reply('{8'h04}, 1'b1, 1'b1);
    auth_locked = 1'b0;
    wr(1'b1, 1'b0, 8'h0A);
    wr(1'b0, 1'b1, 8'h05);
    wr(1'b1, 1'b1, 8'h05);
    $display("test codes done");
  endtask
  initial begin
    {rst_n, write_ok, write_fail, auth_locked, unlocked_state, slow, tv_seen} = 7'h00;
    rx       = '0;
    prot     = 8'hFF;
    variant  = responder_pkg::VAR_144;
    errors   = 0;
    compares = 0;
    cyc      = 0;
    t0       = 0;
    tv_at    = 0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_activation();
    t_version();
    t_read();
    t_protect();
    t_codes();
    final_report();
  end
endmodule // test_tag_read_version_responder

bind tag_read_version_responder responder_monitor #(.REPLY_DELAY_CYC(REPLY_DELAY_CYC)) u_responder_monitor (
  .clk(clk), .rst_n(rst_n), .rx(rx), .write_ok(write_ok), .write_fail(write_fail), .auth_locked(auth_locked),
  .variant(variant), .protection_start_page(protection_start_page), .unlocked_state(unlocked_state),
  .mem_page(mem_page), .mem_rdata(mem_rdata), .tx(tx), .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy)
);
